//--- axis_pulse_pkg.sv
// Package with constants and types shared by the axis pulse profile generator.
package axis_pulse_pkg;
    localparam int unsigned CLOCK_HZ      = 10_000_000;
    localparam int          VEL_W         = 24;
    localparam int          POS_W         = 32;
    localparam int          RATIO_W       = 16;
    localparam int          RATIO_FRAC    = 8;
    localparam int          ACC_W         = 40;
    localparam int          JERK_STEPS    = 4;
    localparam logic [15:0] PULSE_WIDTH_CYCLES = 16'h0005;
    localparam logic [15:0] DIR_SETUP_CYCLES   = 16'h0003;
    localparam logic [RATIO_W-1:0] RATIO_ONE   = 16'h0100;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_VELOCITY,
        CMD_PRESET_REL,
        CMD_PRESET_ABS
    } move_kind_t;

    typedef enum {
        ST_IDLE,
        ST_DIR_SETUP,
        ST_RUN
    } run_state_t;
endpackage

//--- axis_pulse_profile_generator.sv
// Single-axis step pulse and direction generator with velocity and point-to-point moves.
// Contract
// - Motion appears on step and direction lines.
// - Step/direction: pulses on step, level on direction.
// - Pulse count equals distance, rate equals velocity.
// - Direction level encodes positive or negative travel.
// - Pulse polarity is configurable.
// - Clockwise/counter-clockwise: each direction on own line.
// - Velocity mode ramps start to target velocity.
// - Velocity mode holds target until new command.
// - Ramp is linear or eased per command.
// - Speed updates accepted while pulsing.
// - Ramped stop decelerates until output ceases.
// - Immediate stop ends pulses at once.
// - Updates and stops keep current profile shape.
// - Updates and stops also work in preset moves.
// - Preset moves take absolute or relative pulses.
// - Separate acceleration and deceleration times.
// - Ramp rate is velocity change over time.
// - Completion flag shows preset move finished.
// - Absolute moves use encoder feedback position.
// - Move ratio scales command to feedback pulses.
`timescale 1ns/10ps
module axis_pulse_profile_generator #(
    parameter int VEL_W   = axis_pulse_pkg::VEL_W,
    parameter int POS_W   = axis_pulse_pkg::POS_W,
    parameter int RATIO_W = axis_pulse_pkg::RATIO_W
) (
    // Clock and reset.
    input  wire logic               ref_clk_in,
    input  wire logic               reset_in,
    // Output and feedback configuration.
    input  wire logic               dual_pulse_mode_in,
    input  wire logic               pulse_invert_in,
    input  wire logic               feedback_external_in,
    input  wire logic [RATIO_W-1:0] move_ratio_in,
    // Move commands, one-cycle strobes.
    input  wire logic               linear_ramp_velocity_run_in,
    input  wire logic               scurve_velocity_run_in,
    input  wire logic               preset_start_in,
    input  wire logic               preset_absolute_in,
    input  wire logic               preset_scurve_in,
    input  wire logic               velocity_negative_in,
    input  wire logic               speed_change_in,
    input  wire logic               ramped_halt_in,
    input  wire logic               immediate_halt_in,
    // Move parameters.
    input  wire logic [VEL_W-1:0]   start_velocity_in,
    input  wire logic [VEL_W-1:0]   peak_velocity_in,
    input  wire logic [VEL_W-1:0]   accel_slope_in,
    input  wire logic [VEL_W-1:0]   decel_slope_in,
    input  wire logic [POS_W-1:0]   target_in,
    // Encoder feedback pins.
    input  wire logic               feedback_phase_a_in,
    input  wire logic               feedback_phase_b_in,
    // Pulse outputs.
    output logic                    step_out,
    output logic                    direction_out,
    // Status.
    output logic                    busy_out,
    output logic                    motion_done_out,
    output logic [POS_W-1:0]        command_position_out,
    output logic [POS_W-1:0]        feedback_position_out
);
    axis_pulse_pkg::run_state_t state;
    logic                 scurve;
    logic                 preset;
    logic                 negative;
    logic                 stopping;
    logic [POS_W-1:0]     remaining;
    logic [VEL_W-1:0]     target_rate;
    logic [VEL_W-1:0]     floor_rate;
    logic [15:0]          wait_count;
    logic [15:0]          pulse_count;
    logic                 pulse_active;
    logic [31:0]          phase_acc;
    logic [1:0]           sync_a;
    logic [1:0]           sync_b;
    logic                 prev_a;
    logic                 prev_b;
    logic [RATIO_W+POS_W-1:0] feedback_scaled;
    logic [POS_W-1:0]     fb_in_cmd;
    logic [POS_W-1:0]     abs_delta;
    logic                 abs_negative;
    logic [VEL_W-1:0]     rate;
    logic                 ramp_load;
    logic [VEL_W-1:0]     ramp_slope;
    logic [VEL_W-1:0]     ramp_goal;
    logic [VEL_W-1:0]     decel_need;
    logic                 need_decel;
    logic                 emit;
    logic                 start_any;
    logic [32:0]          next_phase;

    assign start_any = linear_ramp_velocity_run_in | scurve_velocity_run_in | preset_start_in;

    // Encoder inputs are pins, so they pass two flip-flops before use.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_a <= '0;
            sync_b <= '0;
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            sync_a <= {sync_a[0], feedback_phase_a_in};
            sync_b <= {sync_b[0], feedback_phase_b_in};
            prev_a <= sync_a[1];
            prev_b <= sync_b[1];
        end
    end

    // Quadrature decode, four counts per cycle of the A and B phases.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            feedback_position_out <= '0;
        end else if ((sync_a[1] ^ prev_a) ^ (sync_b[1] ^ prev_b)) begin
            if (sync_a[1] ^ prev_b) begin
                feedback_position_out <= feedback_position_out + POS_W'(1);
            end else begin
                feedback_position_out <= feedback_position_out - POS_W'(1);
            end
        end
    end

    // Feedback counts divided by the move ratio (fixed point) give command pulses.
    assign feedback_scaled = ((RATIO_W+POS_W)'($signed(feedback_position_out)) <<< axis_pulse_pkg::RATIO_FRAC)
                             / (RATIO_W+POS_W)'((move_ratio_in == '0) ? axis_pulse_pkg::RATIO_ONE : move_ratio_in);
    // Position source for absolute moves: encoder or own command counter.
    assign fb_in_cmd = feedback_external_in ? feedback_scaled[POS_W-1:0] : command_position_out;
    assign abs_negative = $signed(target_in) < $signed(fb_in_cmd);
    assign abs_delta = abs_negative ? fb_in_cmd - target_in : target_in - fb_in_cmd;

    // Remaining pulses needed to slow from the current rate to the floor rate: (v^2 - f^2)/(2*decel).
    assign decel_need = (decel_slope_in == '0) ? '0 :
        VEL_W'(((2*VEL_W)'(rate) * (2*VEL_W)'(rate) - (2*VEL_W)'(floor_rate) * (2*VEL_W)'(floor_rate))
        / ((2*VEL_W)'(decel_slope_in) << 1));
    assign need_decel = preset && (POS_W'(decel_need) >= remaining);

    // Ramp goal and slope: accelerate with one time, decelerate with the other.
    always_comb begin
        ramp_goal  = target_rate;
        ramp_slope = accel_slope_in;
        if (stopping || need_decel) begin
            ramp_goal  = floor_rate;
            ramp_slope = decel_slope_in;
        end else if (rate > target_rate) begin
            ramp_slope = decel_slope_in;
        end
    end

    assign ramp_load = (state == axis_pulse_pkg::ST_IDLE);

    axis_rate_ramp #(
        .VEL_W (VEL_W),
        .ACC_W (axis_pulse_pkg::ACC_W)
    ) u_ramp (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .load_in       (ramp_load),
        .load_value_in (start_velocity_in),
        .enable_in     (state == axis_pulse_pkg::ST_RUN),
        .scurve_in     (scurve),
        .target_in     (ramp_goal),
        .slope_in      (ramp_slope),
        .rate_out      (rate),
        .at_target_out ()
    );

    // Phase accumulator: carry rate equals the ramp rate in pulses per second.
    assign next_phase = {1'b0, phase_acc} + 33'(rate);
    assign emit = (state == axis_pulse_pkg::ST_RUN) && !pulse_active &&
                  (next_phase >= 33'(axis_pulse_pkg::CLOCK_HZ)) &&
                  !(preset && remaining == '0);

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_acc <= '0;
        end else if (state != axis_pulse_pkg::ST_RUN) begin
            phase_acc <= '0;
        end else if (next_phase >= 33'(axis_pulse_pkg::CLOCK_HZ)) begin
            phase_acc <= 32'(next_phase - 33'(axis_pulse_pkg::CLOCK_HZ));
        end else begin
            phase_acc <= next_phase[31:0];
        end
    end

    // Pulse width timer; a new pulse never starts while one is high.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pulse_active <= 1'b0;
            pulse_count  <= '0;
        end else if (immediate_halt_in) begin
            pulse_active <= 1'b0;
            pulse_count  <= '0;
        end else if (emit) begin
            pulse_active <= 1'b1;
            pulse_count  <= axis_pulse_pkg::PULSE_WIDTH_CYCLES - 16'h0001;
        end else if (pulse_active) begin
            if (pulse_count == '0) begin
                pulse_active <= 1'b0;
            end else begin
                pulse_count <= pulse_count - 16'h0001;
            end
        end
    end

    // Move sequencer.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state       <= axis_pulse_pkg::ST_IDLE;
            scurve      <= 1'b0;
            preset      <= 1'b0;
            negative    <= 1'b0;
            stopping    <= 1'b0;
            remaining   <= '0;
            target_rate <= '0;
            floor_rate  <= '0;
            wait_count  <= '0;
        end else if (immediate_halt_in) begin
            state    <= axis_pulse_pkg::ST_IDLE;
            stopping <= 1'b0;
        end else begin
            case (state)
                axis_pulse_pkg::ST_IDLE: begin
                    if (start_any) begin
                        scurve      <= scurve_velocity_run_in | (preset_start_in & preset_scurve_in);
                        preset      <= preset_start_in;
                        target_rate <= peak_velocity_in;
                        floor_rate  <= start_velocity_in;
                        stopping    <= 1'b0;
                        wait_count  <= axis_pulse_pkg::DIR_SETUP_CYCLES;
                        state       <= axis_pulse_pkg::ST_DIR_SETUP;
                        if (preset_start_in && preset_absolute_in) begin
                            remaining <= abs_delta;
                            negative  <= abs_negative;
                        end else if (preset_start_in) begin
                            remaining <= $signed(target_in) < 0 ? -target_in : target_in;
                            negative  <= target_in[POS_W-1];
                        end else begin
                            remaining <= '0;
                            negative  <= velocity_negative_in;
                        end
                    end
                end
                axis_pulse_pkg::ST_DIR_SETUP: begin
                    // Direction is already at its new level; wait before the first pulse.
                    if (wait_count == '0) begin
                        state <= axis_pulse_pkg::ST_RUN;
                    end else begin
                        wait_count <= wait_count - 16'h0001;
                    end
                    if (ramped_halt_in) begin
                        state <= axis_pulse_pkg::ST_IDLE;
                    end
                end
                axis_pulse_pkg::ST_RUN: begin
                    if (speed_change_in) begin
                        target_rate <= peak_velocity_in;
                    end
                    if (ramped_halt_in) begin
                        stopping <= 1'b1;
                    end
                    if (emit && preset) begin
                        remaining <= remaining - POS_W'(1);
                    end
                    if (!pulse_active && !emit &&
                        ((preset && remaining == '0) || (stopping && rate <= floor_rate))) begin
                        state <= axis_pulse_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= axis_pulse_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Command position follows every emitted pulse.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            command_position_out <= '0;
        end else if (emit) begin
            command_position_out <= negative ? command_position_out - POS_W'(1)
                                             : command_position_out + POS_W'(1);
        end
    end

    // Output lines: single mode puts pulses on step and level on direction,
    // dual mode puts positive pulses on step and negative pulses on direction.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            step_out      <= 1'b0;
            direction_out <= 1'b0;
        end else if (dual_pulse_mode_in) begin
            step_out      <= (pulse_active & ~negative) ^ pulse_invert_in;
            direction_out <= (pulse_active & negative) ^ pulse_invert_in;
        end else begin
            step_out      <= pulse_active ^ pulse_invert_in;
            if (!pulse_active) begin
                direction_out <= negative;
            end
        end
    end

    // Completion flag: set whenever the sequencer is idle after any move or halt, cleared at any new start.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            motion_done_out <= 1'b1;
        end else if (start_any && state == axis_pulse_pkg::ST_IDLE) begin
            motion_done_out <= 1'b0;
        end else if (state == axis_pulse_pkg::ST_IDLE) begin
            motion_done_out <= 1'b1;
        end
    end

    assign busy_out = (state != axis_pulse_pkg::ST_IDLE);
endmodule // axis_pulse_profile_generator

//--- axis_pulse_profile_generator_asserts.sv
// Concurrent checks on the pulse lines and status of the axis pulse profile generator.
`timescale 1ns/10ps
module axis_pulse_checker (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Configuration and commands.
    input wire logic dual_pulse_mode_in,
    input wire logic pulse_invert_in,
    input wire logic linear_ramp_velocity_run_in,
    input wire logic scurve_velocity_run_in,
    input wire logic preset_start_in,
    input wire logic immediate_halt_in,
    // Watched outputs.
    input wire logic step_out,
    input wire logic direction_out,
    input wire logic busy_out,
    input wire logic motion_done_out
);
    logic [2:0] halt_q;
    wire        step_act = step_out ^ pulse_invert_in;
    wire        dir_act  = direction_out ^ pulse_invert_in;
    wire        start    = preset_start_in | linear_ramp_velocity_run_in | scurve_velocity_run_in;
    wire        halted   = immediate_halt_in | (|halt_q);

    // A halt may cut a pulse short, so width checks rest for a few cycles after it.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            halt_q <= 3'h0;
        end else begin
            halt_q <= {halt_q[1:0], immediate_halt_in};
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    a_start_sets_busy: assert property (start && !busy_out |=> busy_out && !motion_done_out)
        else $error("busy did not follow a start");
    a_busy_not_done: assert property (busy_out |-> !motion_done_out)
        else $error("done shown while busy");
    a_step_width_five: assert property (disable iff (reset_in || halted)
        $rose(step_act) && $past(busy_out) |-> step_act[*5] ##1 !step_act) else $error("step pulse width wrong");
    a_ccw_width_five: assert property (disable iff (reset_in || halted)
        $rose(dir_act) && dual_pulse_mode_in && $past(busy_out) |-> dir_act[*5] ##1 !dir_act)
        else $error("second line pulse width wrong");
    a_dir_steady: assert property (!dual_pulse_mode_in && busy_out && step_act |-> $stable(direction_out))
        else $error("direction moved during a pulse");
    a_dir_setup: assert property ($rose(busy_out) && !dual_pulse_mode_in |-> !step_act[*3])
        else $error("step came before direction setup");
    a_lines_apart: assert property (dual_pulse_mode_in && busy_out |-> !(step_act && dir_act))
        else $error("both pulse lines active");
    a_halt_at_once: assert property (busy_out && immediate_halt_in |->
        ##[1:2] (!busy_out && !step_act && !(dual_pulse_mode_in && dir_act))) else $error("halt did not stop");

    c_preset_run: cover property (preset_start_in && !busy_out);
    c_halt_busy: cover property (busy_out && immediate_halt_in);
    c_ccw_pulse: cover property (dual_pulse_mode_in && $rose(dir_act));
endmodule // axis_pulse_checker

bind axis_pulse_profile_generator axis_pulse_checker chk (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .dual_pulse_mode_in(dual_pulse_mode_in),
    .pulse_invert_in(pulse_invert_in),
    .linear_ramp_velocity_run_in(linear_ramp_velocity_run_in),
    .scurve_velocity_run_in(scurve_velocity_run_in),
    .preset_start_in(preset_start_in),
    .immediate_halt_in(immediate_halt_in),
    .step_out(step_out),
    .direction_out(direction_out),
    .busy_out(busy_out),
    .motion_done_out(motion_done_out)
);

//--- axis_pulse_profile_generator_test.sv
// Self-checking bench for the axis pulse profile generator with a driver model.
`timescale 1ns/10ps
module axis_pulse_profile_generator_test;
    logic ref_clk_in = 1'b0, reset_in = 1'b1, dual_pulse_mode_in = 1'b0, pulse_invert_in = 1'b0;
    logic feedback_external_in = 1'b0, linear_ramp_velocity_run_in = 1'b0, scurve_velocity_run_in = 1'b0;
    logic preset_start_in = 1'b0, preset_absolute_in = 1'b0, preset_scurve_in = 1'b0;
    logic velocity_negative_in = 1'b0, speed_change_in = 1'b0, ramped_halt_in = 1'b0, immediate_halt_in = 1'b0;
    logic        [15:0] move_ratio_in = 16'h0100;
    logic        [23:0] start_velocity_in = 24'h0186a0, peak_velocity_in = 24'h0186a0;
    logic        [23:0] accel_slope_in = 24'hffffff, decel_slope_in = 24'hffffff;
    logic        [31:0] target_in = 32'h0, command_position_out, feedback_position_out, c0;
    logic feedback_phase_a_in, feedback_phase_b_in, step_out, direction_out, busy_out, motion_done_out;
    logic signed [31:0] motor_pos, p0, d;
    int                 errors = 0, n_checks = 0, k;

    always #50 ref_clk_in = ~ref_clk_in;

    axis_pulse_profile_generator dut (.ref_clk_in, .reset_in, .dual_pulse_mode_in, .pulse_invert_in,
        .feedback_external_in, .move_ratio_in, .linear_ramp_velocity_run_in, .scurve_velocity_run_in,
        .preset_start_in, .preset_absolute_in, .preset_scurve_in, .velocity_negative_in, .speed_change_in,
        .ramped_halt_in, .immediate_halt_in, .start_velocity_in, .peak_velocity_in, .accel_slope_in,
        .decel_slope_in, .target_in, .feedback_phase_a_in, .feedback_phase_b_in, .step_out, .direction_out,
        .busy_out, .motion_done_out, .command_position_out, .feedback_position_out);

    motor_driver_model drv (.ref_clk_in, .reset_in, .dual_mode_in(dual_pulse_mode_in),
        .invert_in(pulse_invert_in), .line_a_in(step_out), .line_b_in(direction_out),
        .position_out(motor_pos), .phase_a_out(feedback_phase_a_in), .phase_b_out(feedback_phase_b_in));

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic logic [31:0] near(input logic [31:0] n, input logic [31:0] e);
        return 32'((n + 1 >= e) && (n <= e + 1));
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic strobe(ref logic s);
        s = 1'b1;
        @(negedge ref_clk_in);
        s = 1'b0;
    endtask

    task automatic wait_idle(input int lim);
        int i;
        for (i = 0; i < lim && busy_out !== 1'b0; i++) @(negedge ref_clk_in);
        repeat (8) @(negedge ref_clk_in);
        if (i == lim) begin
            check(32'h1, 32'h0);
            wrap_up();
        end
    endtask

    task automatic window(input int cyc, input logic [31:0] e);
        logic signed [31:0] p;
        p = motor_pos;
        repeat (cyc) @(negedge ref_clk_in);
        check(near(mag(motor_pos - p), e), 32'h1);
    endtask

    initial begin
        void'($urandom(32'hd3f1));
        repeat (16) @(negedge ref_clk_in);
        reset_in = 1'b0;
        @(negedge ref_clk_in);
        // Relative moves in every format and polarity; one start is repeated while busy.
        for (k = 0; k < 6; k++) begin
            {preset_scurve_in, pulse_invert_in, dual_pulse_mode_in} = 3'(k);
            d = (k == 0) ? 32'sd1 : 32'($urandom_range(12, 2));
            if ($urandom_range(1, 0) == 1) d = -d;
            target_in = d;
            p0 = motor_pos;
            c0 = command_position_out;
            repeat (2) @(negedge ref_clk_in);
            strobe(preset_start_in);
            if (k == 3) begin
                @(negedge ref_clk_in);
                strobe(preset_start_in);
            end
            wait_idle(1600);
            check(32'(motion_done_out), 32'h1);
            check(command_position_out - c0, d);
            if (k[0]) check(motor_pos - p0, d);
            else check(mag(motor_pos - p0), mag(d));
        end
        // Absolute moves on encoder feedback, ratio one and ratio zero.
        {dual_pulse_mode_in, pulse_invert_in, feedback_external_in, preset_absolute_in} = 4'hb;
        for (k = 0; k < 2; k++) begin
            move_ratio_in = k[0] ? 16'h0000 : 16'h0100;
            d = 32'($urandom_range(9, 2));
            if (k == 1) d = -d;
            target_in = feedback_position_out + d;
            p0 = motor_pos;
            repeat (2) @(negedge ref_clk_in);
            strobe(preset_start_in);
            wait_idle(1400);
            check(feedback_position_out, target_in);
            check(motor_pos - p0, d);
        end
        {feedback_external_in, preset_absolute_in} = 2'h0;
        // Long move cut short by an immediate halt.
        target_in = 32'd1000;
        p0 = motor_pos;
        strobe(preset_start_in);
        repeat (3000) @(negedge ref_clk_in);
        strobe(immediate_halt_in);
        wait_idle(4);
        check(32'(motor_pos - p0 < 1000), 32'h1);
        // Velocity runs, linear then eased, speed change on the linear run only, ramped halt on both.
        dual_pulse_mode_in = 1'b0;
        peak_velocity_in = 24'h01adb0;
        for (k = 0; k < 2; k++) begin
            velocity_negative_in = 1'($urandom_range(1, 0));
            repeat (2) @(negedge ref_clk_in);
            if (k == 0) strobe(linear_ramp_velocity_run_in);
            else strobe(scurve_velocity_run_in);
            repeat (13000) @(negedge ref_clk_in);
            window(4000, 32'd44);
            check(32'(busy_out), 32'h1);
            if (k == 0) begin
                peak_velocity_in = 24'h0186a0;
                strobe(speed_change_in);
                repeat (7000) @(negedge ref_clk_in);
                window(4000, 32'd40);
                peak_velocity_in = 24'h01adb0;
            end
            strobe(ramped_halt_in);
            repeat (50) @(negedge ref_clk_in);
            if (k == 1) check(32'(busy_out), 32'h1);
            wait_idle(16000);
        end
        wrap_up();
    end
endmodule // axis_pulse_profile_generator_test

//--- axis_rate_ramp.sv
// Velocity ramp that moves the current rate toward a target, linearly or with eased arrival at the target.
`timescale 1ns/10ps
module axis_rate_ramp #(
    parameter int VEL_W = 24,
    parameter int ACC_W = 40
) (
    // Clock and reset.
    input  wire logic             ref_clk_in,
    input  wire logic             reset_in,
    // Control.
    input  wire logic             load_in,
    input  wire logic [VEL_W-1:0] load_value_in,
    input  wire logic             enable_in,
    input  wire logic             scurve_in,
    input  wire logic [VEL_W-1:0] target_in,
    input  wire logic [VEL_W-1:0] slope_in,
    // Result.
    output logic      [VEL_W-1:0] rate_out,
    output logic                  at_target_out
);
    logic [ACC_W-1:0] accum;
    logic [VEL_W-1:0] step_now;
    logic [VEL_W-1:0] gap;
    logic [VEL_W-1:0] next_rate;
    logic [ACC_W-1:0] next_accum;
    logic [ACC_W-1:0] sum;

    assign gap = (rate_out > target_in) ? rate_out - target_in : target_in - rate_out;

    // The eased shape halves the slope while within one slope of the target, giving a softened corner.
    always_comb begin
        step_now = slope_in;
        if (scurve_in && (gap < slope_in)) begin
            step_now = slope_in >> 1;
        end
        sum        = accum + ACC_W'(step_now);
        next_accum = accum;
        next_rate  = rate_out;
        if (enable_in && gap != '0) begin
            if (sum >= ACC_W'(axis_pulse_pkg::CLOCK_HZ)) begin
                next_accum = sum - ACC_W'(axis_pulse_pkg::CLOCK_HZ);
                if (rate_out < target_in) begin
                    next_rate = rate_out + VEL_W'(1);
                end else begin
                    next_rate = rate_out - VEL_W'(1);
                end
            end else begin
                next_accum = sum;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rate_out <= '0;
            accum    <= '0;
        end else if (load_in) begin
            rate_out <= load_value_in;
            accum    <= '0;
        end else begin
            rate_out <= next_rate;
            accum    <= next_accum;
        end
    end

    assign at_target_out = (gap == '0);
endmodule // axis_rate_ramp

//--- motor_driver_model.sv
// Driver input stage model that turns command pulses into motion and encoder phases.
`timescale 1ns/10ps
module motor_driver_model (
    // Clock and reset.
    input  wire logic          ref_clk_in,
    input  wire logic          reset_in,
    // Line format.
    input  wire logic          dual_mode_in,
    input  wire logic          invert_in,
    // Command lines.
    input  wire logic          line_a_in,
    input  wire logic          line_b_in,
    // Motion and encoder.
    output logic signed [31:0] position_out,
    output logic               phase_a_out,
    output logic               phase_b_out
);
    logic       a_q;
    logic       b_q;
    logic       inv_q;
    logic       dual_q;
    logic [1:0] quad;
    // A polarity or format change flips the idle level, which must not count as a pulse.
    wire        same = (invert_in == inv_q) && (dual_mode_in == dual_q);
    wire        a_act = line_a_in ^ invert_in;
    wire        b_act = line_b_in ^ invert_in;
    wire        a_edge = a_act & !a_q & same;
    wire        fwd = dual_mode_in ? a_edge : a_edge & line_b_in;
    wire        rev = dual_mode_in ? b_act & !b_q & same : a_edge & !line_b_in;

    assign phase_a_out = quad[1] ^ quad[0];
    assign phase_b_out = quad[1];

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            {a_q, b_q, inv_q, dual_q} <= 4'h0;
            position_out <= 32'sh0;
            quad <= 2'h0;
        end else begin
            {a_q, b_q, inv_q, dual_q} <= {a_act, b_act, invert_in, dual_mode_in};
            position_out <= position_out + 32'(fwd) - 32'(rev);
            quad <= quad + 2'(fwd) - 2'(rev);
        end
    end
endmodule // motor_driver_model
